/* File: core/rsc_controller.sv */
// rsc_controller: relay selection, debounce, indicators and remote answers.
// assumes pins arrive asynchronously; remote requests are one-cycle core_clk pulses.
// What this block does
// RULE_01: primary mode leaves channel one only for good two
// RULE_02: primary mode returns when one clears or both alarm
// RULE_03: latch mode holds channel two once taken
// RULE_04: only switch reset releases latched channel two; here manual mode also clears the latch
// RULE_05: minimum mode leaves alarmed active for clear other
// RULE_06: minimum mode switches back under same condition
// RULE_07: relay position survives power loss, no default
// RULE_08: alarm polarity chosen by rear switch
// RULE_09: rear switches choose among three auto policies
// RULE_10: selector forces channel or hands to auto
// RULE_11: remote select only in auto; status reported
// RULE_12: resets accepted from panel or remote
// RULE_13: leds show alarms, mode and supplies
// RULE_14: fault output closes on internal fault or power loss
// RULE_15: remote serial link at 9600 baud, selectable signalling
// RULE_16: remote set enters remote mode until reset; here manual mode also ends it
// RULE_17: remote set answers less-than or greater-than
// RULE_18: pins synchronised and debounced before use; policy_pin and serial_rs422_pin are only synchronised
// RULE_19: history reset clears history, keeps relay
`timescale 1ns/1ns
module rsc_controller #(
    parameter int unsigned DEBOUNCE_CYCLES = rsc_pkg::DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // alarm and panel pins (asynchronous)
    input wire logic channel_one_alarm_pin,
    input wire logic channel_two_alarm_pin,
    input wire rsc_pkg::rsc_selector_t selector_pin,
    input wire rsc_pkg::rsc_reset_req_t panel_button_pin,
    input wire logic supply_a_ok_pin,
    input wire logic supply_b_ok_pin,
    input wire logic internal_fault_pin,
    // rear configuration switches (asynchronous)
    input wire logic alarm_on_closure_pin,
    input wire logic [1:0] policy_pin,
    input wire logic serial_rs422_pin,
    // relay position sense, retained by the latching relay
    input wire logic relay_at_two_pin,
    // remote requests from the command decoder (core_clk domain)
    input wire logic remote_set_valid,
    input wire logic remote_set_two,
    input wire rsc_pkg::rsc_reset_req_t remote_reset,
    // indicators and relay drive
    output rsc_pkg::rsc_leds_t leds,
    output logic relay_pulse_one,
    output logic relay_pulse_two,
    output logic selected_two,
    // fault contact: high closes it to ground
    output logic fault_closed,
    // remote answer byte
    output logic reply_valid,
    output logic [7:0] reply_data,
    // monitoring
    output rsc_pkg::rsc_history_t history,
    output logic serial_rs422,
    output logic [15:0] baud_divisor
);
    import rsc_pkg::*;

    localparam int NPIN = 11; // pins passing through sync and debounce

    // raw pins packed for a common synchroniser
    logic [NPIN-1:0] raw_pins;
    logic [NPIN-1:0] sync1_reg; // first stage, read only by sync2
    logic [NPIN-1:0] sync2_reg;
    logic [NPIN-1:0] clean_reg; // debounced levels
    logic [NPIN-1:0][31:0] settle_reg; // per-pin stability counters
    logic [NPIN-1:0] clean_d_reg; // for edge detection on buttons

    assign raw_pins = {channel_one_alarm_pin, channel_two_alarm_pin, selector_pin,
                       panel_button_pin, supply_a_ok_pin, supply_b_ok_pin,
                       internal_fault_pin, alarm_on_closure_pin, relay_at_two_pin};

    // two-flop synchroniser for every pin
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= raw_pins; // RULE_18
            sync2_reg <= sync1_reg;
        end
    end

    // debounce: accept a new level only after it has held steady
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clean_reg <= '0;
            settle_reg <= '0;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                if (sync2_reg[i] == clean_reg[i]) begin
                    settle_reg[i] <= '0;
                end else if (settle_reg[i] >= DEBOUNCE_CYCLES - 1) begin
                    clean_reg[i] <= sync2_reg[i]; // RULE_18
                    settle_reg[i] <= '0;
                end else begin
                    settle_reg[i] <= settle_reg[i] + 32'h1;
                end
            end
        end
    end

    // rear policy bits are static straps; two flops are enough
    logic [1:0] pol_s1_reg;
    logic [1:0] pol_s2_reg;
    logic rs_s1_reg;
    logic rs_s2_reg;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pol_s1_reg <= '0;
            pol_s2_reg <= '0;
            rs_s1_reg <= 1'b0;
            rs_s2_reg <= 1'b0;
        end else begin
            pol_s1_reg <= policy_pin;
            pol_s2_reg <= pol_s1_reg;
            rs_s1_reg <= serial_rs422_pin;
            rs_s2_reg <= rs_s1_reg;
        end
    end

    // named debounced signals
    logic a1_raw, a2_raw, sel_one, sel_two, btn_sw, btn_hist;
    logic sup_a, sup_b, int_fault, on_closure, relay_two_sense;
    logic btn_sw_edge, btn_hist_edge;
    assign {a1_raw, a2_raw, sel_one, sel_two, btn_sw, btn_hist,
            sup_a, sup_b, int_fault, on_closure, relay_two_sense} = clean_reg;
    assign btn_sw_edge = clean_reg[6] & ~clean_d_reg[6];
    assign btn_hist_edge = clean_reg[5] & ~clean_d_reg[5];

    // alarm polarity: closure to ground reads as low on the pin
    logic alarm_one, alarm_two;
    assign alarm_one = on_closure ? ~a1_raw : a1_raw; // RULE_08
    assign alarm_two = on_closure ? ~a2_raw : a2_raw; // RULE_08

    logic manual_mode, switch_reset, history_reset;
    rsc_policy_t policy;
    assign manual_mode = sel_one | sel_two; // RULE_10
    assign policy = rsc_policy_t'(pol_s2_reg); // RULE_09
    assign switch_reset = btn_sw_edge | remote_reset.switch_reset; // RULE_12
    assign history_reset = btn_hist_edge | remote_reset.history_reset; // RULE_12

    // selection state
    logic sel_two_reg; // present choice, high for channel two
    logic latched_reg; // latch policy hold
    logic remote_reg; // remote mode active
    logic restored_reg; // relay sense taken after reset
    logic sel_two_next;
    // sync stages plus debounce: sense is trustworthy only after this many cycles
    localparam int unsigned RESTORE_WAIT = DEBOUNCE_CYCLES + 3;
    logic [31:0] restore_cnt_reg; // cycles since reset release, saturating

    // next channel from mode and policy
    always_comb begin
        sel_two_next = sel_two_reg;
        if (!restored_reg) begin
            sel_two_next = relay_two_sense; // RULE_07
        end else if (manual_mode) begin
            sel_two_next = sel_two; // RULE_10
        end else if (remote_set_valid) begin
            sel_two_next = remote_set_two; // RULE_11
        end else if (remote_reg) begin
            sel_two_next = sel_two_reg; // remote holds its position
        end else begin
            case (policy)
                RSC_PRIMARY_PREFERRED_POLICY: begin
                    if (!sel_two_reg && alarm_one && !alarm_two) begin
                        sel_two_next = 1'b1; // RULE_01
                    end else if (sel_two_reg && (!alarm_one || alarm_two)) begin
                        sel_two_next = 1'b0; // RULE_02
                    end
                end
                RSC_LATCH_SECOND_POLICY: begin
                    if (switch_reset) begin
                        sel_two_next = 1'b0; // RULE_04
                    end else if (latched_reg) begin
                        sel_two_next = 1'b1; // RULE_03
                    end else if (alarm_one && !alarm_two) begin
                        sel_two_next = 1'b1; // RULE_03
                    end else begin
                        sel_two_next = 1'b0;
                    end
                end
                RSC_MINIMUM_SWITCHING_POLICY: begin
                    if (!sel_two_reg && alarm_one && !alarm_two) begin
                        sel_two_next = 1'b1; // RULE_05
                    end else if (sel_two_reg && alarm_two && !alarm_one) begin
                        sel_two_next = 1'b0; // RULE_06
                    end
                end
                default: begin
                    sel_two_next = sel_two_reg; // spare setting holds position
                end
            endcase
        end
    end

    // selection, latch and remote mode registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_two_reg <= 1'b0;
            latched_reg <= 1'b0;
            remote_reg <= 1'b0;
            restored_reg <= 1'b0;
            restore_cnt_reg <= '0;
            clean_d_reg <= '0;
        end else begin
            clean_d_reg <= clean_reg;
            // debounced levels start at zero, so wait until sense has passed the filter
            restore_cnt_reg <= (restore_cnt_reg < RESTORE_WAIT) ? restore_cnt_reg + 32'h1
                : restore_cnt_reg;
            restored_reg <= restored_reg | (restore_cnt_reg >= RESTORE_WAIT); // RULE_07
            sel_two_reg <= sel_two_next;
            if (switch_reset || manual_mode) begin
                latched_reg <= 1'b0; // RULE_04
            end else if (policy == RSC_LATCH_SECOND_POLICY && sel_two_next && !remote_reg) begin
                latched_reg <= 1'b1; // RULE_03
            end
            if (switch_reset || manual_mode) begin
                remote_reg <= 1'b0; // RULE_16
            end else if (remote_set_valid) begin
                remote_reg <= 1'b1; // RULE_16
            end
        end
    end

    // once restored_reg is set, relay coil pulses whenever the choice differs from the sensed position
    always_ff @(posedge core_clk) begin
        if (rst) begin
            relay_pulse_one <= 1'b0;
            relay_pulse_two <= 1'b0;
            selected_two <= 1'b0;
        end else begin
            relay_pulse_one <= restored_reg & ~sel_two_reg & relay_two_sense;
            relay_pulse_two <= restored_reg & sel_two_reg & ~relay_two_sense;
            selected_two <= sel_two_reg;
        end
    end

    // remote answer characters
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reply_valid <= 1'b0;
            reply_data <= 8'h00;
        end else begin
            reply_valid <= remote_set_valid; // RULE_17
            if (remote_set_valid) begin
                reply_data <= manual_mode ? REPLY_REFUSED : REPLY_DONE; // RULE_17
            end
        end
    end

    // indicators, fault contact and serial configuration
    always_ff @(posedge core_clk) begin
        if (rst) begin
            leds <= '0;
            fault_closed <= FAULT_OPEN;
            serial_rs422 <= 1'b0;
            baud_divisor <= 16'h0000;
        end else begin
            leds.channel_one_alarm <= alarm_one; // RULE_13
            leds.channel_two_alarm <= alarm_two; // RULE_13
            leds.remote_mode <= remote_reg; // RULE_16
            leds.manual_mode <= manual_mode; // RULE_13
            leds.supply_a_on <= sup_a; // RULE_13
            leds.supply_b_on <= sup_b; // RULE_13
            // losing both supplies also closes the contact
            fault_closed <= int_fault | ~(sup_a | sup_b); // RULE_14
            serial_rs422 <= rs_s2_reg; // RULE_15
            baud_divisor <= 16'(BAUD_DIV); // RULE_15
        end
    end

    // event history, cleared only by rst or history reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            history <= '0;
        end else begin
            // a new event in the clearing cycle wins over the clear
            history.channel_one_alarmed <= (history.channel_one_alarmed & ~history_reset)
                | alarm_one; // RULE_19
            history.channel_two_alarmed <= (history.channel_two_alarmed & ~history_reset)
                | alarm_two; // RULE_19
            history.switched <= (history.switched & ~history_reset)
                | (restored_reg & (sel_two_next != sel_two_reg)); // RULE_19
        end
    end

endmodule : rsc_controller

/* File: shared/rsc_pkg.sv */
// rsc_pkg: shared types and constants for the redundancy switch controller.
// assumes a single 250 MHz core clock and a synchronous active-high reset.
package rsc_pkg;

    // clock rate and derived timing
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned DEBOUNCE_US = 1000; // contact settle time, microseconds
    localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
    localparam int unsigned BAUD_RATE = 9600; // remote serial rate
    localparam int unsigned BAUD_DIV = CLK_HZ / BAUD_RATE;

    // answer characters for remote position requests
    localparam logic [7:0] REPLY_REFUSED = 8'h3C; // '<'
    localparam logic [7:0] REPLY_DONE = 8'h3E; // '>'

    // reset values
    localparam logic FAULT_OPEN = 1'b0;

    // automatic policy encoding from rear switches
    typedef enum logic [1:0] {
        RSC_PRIMARY_PREFERRED_POLICY = 2'h0,
        RSC_LATCH_SECOND_POLICY = 2'h1,
        RSC_MINIMUM_SWITCHING_POLICY = 2'h2,
        RSC_POLICY_SPARE = 2'h3
    } rsc_policy_t;

    // front-panel selector contacts
    typedef struct packed {
        logic force_channel_one;
        logic force_channel_two;
    } rsc_selector_t;

    // momentary requests, front panel or remote
    typedef struct packed {
        logic switch_reset;
        logic history_reset;
    } rsc_reset_req_t;

    // indicator outputs
    typedef struct packed {
        logic channel_one_alarm;
        logic channel_two_alarm;
        logic remote_mode;
        logic manual_mode;
        logic supply_a_on;
        logic supply_b_on;
    } rsc_leds_t;

    // recorded past events
    typedef struct packed {
        logic channel_one_alarmed;
        logic channel_two_alarmed;
        logic switched;
    } rsc_history_t;

endpackage : rsc_pkg

/* File: sim/rsc_checker.sv */
// rsc_checker: concurrent checks on the controller's top-level ports.
// assumes one core_clk domain with a synchronous active-high rst.
`timescale 1ns/1ns
module rsc_checker #(
    parameter int unsigned DEBOUNCE_CYCLES = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // watched inputs
    input wire logic internal_fault_pin,
    input wire logic relay_at_two_pin,
    input wire logic remote_set_valid,
    input wire logic remote_set_two,
    // watched outputs
    input wire rsc_pkg::rsc_leds_t leds,
    input wire logic relay_pulse_one,
    input wire logic relay_pulse_two,
    input wire logic selected_two,
    input wire logic fault_closed,
    input wire logic reply_valid,
    input wire logic [7:0] reply_data,
    input wire logic [15:0] baud_divisor
);
    import rsc_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    int fault_run; // cycles the fault pin has stood high
    int match_run; // cycles the choice has agreed with the relay pin
    // sense lags the pin through sync and debounce, so count before judging
    always_ff @(posedge core_clk) begin
        if (rst || selected_two != relay_at_two_pin) begin
            match_run <= 0;
        end else if (match_run < 1000) begin
            match_run <= match_run + 1;
        end
    end
    // a counter instead of a long repetition keeps the tools fast
    always_ff @(posedge core_clk) begin
        if (rst || !internal_fault_pin) begin
            fault_run <= 0;
        end else if (fault_run < 1000) begin
            fault_run <= fault_run + 1;
        end
    end
    // request taken while the panel selector is at auto
    sequence s_accept;
        remote_set_valid && !leds.manual_mode;
    endsequence
    // answer, then new position and remote lamp
    sequence s_enter;
        reply_data == REPLY_DONE ##1 (leds.remote_mode && selected_two == $past(remote_set_two, 2));
    endsequence
    a_reply_next: assert property (remote_set_valid |=> reply_valid)
        else $error("no answer one cycle after a remote request");
    a_reply_cause: assert property (reply_valid |-> $past(remote_set_valid))
        else $error("answer without a remote request");
    a_refuse_manual: assert property (remote_set_valid && leds.manual_mode |=>
        reply_data == REPLY_REFUSED && $stable(selected_two))
        else $error("remote request in manual mode was not refused");
    a_remote_enter: assert property (s_accept |-> ##1 s_enter)
        else $error("accepted remote request did not take effect");
    a_relay_drive: assert property ((selected_two && !relay_at_two_pin)[*3] |->
        relay_pulse_two && !relay_pulse_one)
        else $error("relay not driven toward channel two");
    a_relay_rest: assert property (match_run > DEBOUNCE_CYCLES + 3 &&
        selected_two == relay_at_two_pin |-> !relay_pulse_one && !relay_pulse_two)
        else $error("relay driven while already in place");
    a_fault_close: assert property (fault_run > DEBOUNCE_CYCLES + 6 |-> fault_closed)
        else $error("fault contact open during internal fault");
    a_baud_fixed: assert property ((!rst)[*3] |-> baud_divisor == 16'h65B9)
        else $error("baud divisor wrong");
endmodule : rsc_checker
bind rsc_controller rsc_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_checker (
    .core_clk(core_clk), .rst(rst), .internal_fault_pin(internal_fault_pin),
    .relay_at_two_pin(relay_at_two_pin), .remote_set_valid(remote_set_valid),
    .remote_set_two(remote_set_two), .leds(leds), .relay_pulse_one(relay_pulse_one),
    .relay_pulse_two(relay_pulse_two), .selected_two(selected_two),
    .fault_closed(fault_closed), .reply_valid(reply_valid), .reply_data(reply_data),
    .baud_divisor(baud_divisor));

/* File: sim/rsc_partner.sv */
// rsc_partner: latching relay and the two channels' alarm contacts.
// assumes coil pulses in core_clk; alarm states are set by the bench.
`timescale 1ns/1ns
module rsc_partner #(
    parameter int SETTLE = 3 // cycles of coil drive before the relay moves
) (
    // clock
    input wire logic core_clk,
    // coil drive
    input wire logic relay_pulse_one,
    input wire logic relay_pulse_two,
    // channel states and rear polarity
    input wire logic channel_one_bad,
    input wire logic channel_two_bad,
    input wire logic alarm_on_closure,
    // contacts seen by the controller
    output logic channel_one_alarm_pin,
    output logic channel_two_alarm_pin,
    output logic relay_at_two_pin
);
    int move_cnt = 0; // coil drive time so far
    logic relay_reg = 1'b0; // no reset input: the position outlives rst
    // closure polarity pulls the pin low on alarm
    assign channel_one_alarm_pin = channel_one_bad ^ alarm_on_closure;
    assign channel_two_alarm_pin = channel_two_bad ^ alarm_on_closure;
    assign relay_at_two_pin = relay_reg;
    // slow relay: a short pulse would leave it where it was
    always @(posedge core_clk) begin
        if ((relay_pulse_two && !relay_reg) || (relay_pulse_one && relay_reg)) begin
            if (move_cnt == SETTLE) begin
                relay_reg <= !relay_reg;
                move_cnt <= 0;
            end else begin
                move_cnt <= move_cnt + 1;
            end
        end else begin
            move_cnt <= 0;
        end
    end
endmodule : rsc_partner

/* File: sim/tb_top.sv */
// tb_top: directed tests of the redundancy switch controller.
// assumes the relay partner model; inputs change at the falling edge.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
    import rsc_pkg::*;
    logic core_clk, rst, one_bad, two_bad, sup_a, sup_b, fault_pin, closure, rs422, set_valid;
    logic set_two, a1_pin, a2_pin, at_two, pulse_one, pulse_two, sel_two, fault_closed;
    logic reply_valid, serial_rs422;
    logic [1:0] policy;
    logic [7:0] reply_data;
    logic [15:0] baud;
    rsc_selector_t selector;
    rsc_reset_req_t panel, remote_reset;
    rsc_leds_t leds;
    rsc_history_t history;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    rsc_controller #(.DEBOUNCE_CYCLES(4)) i_dut (.core_clk(core_clk), .rst(rst),
        .channel_one_alarm_pin(a1_pin), .channel_two_alarm_pin(a2_pin), .selector_pin(selector),
        .panel_button_pin(panel), .supply_a_ok_pin(sup_a), .supply_b_ok_pin(sup_b),
        .internal_fault_pin(fault_pin), .alarm_on_closure_pin(closure), .policy_pin(policy),
        .serial_rs422_pin(rs422), .relay_at_two_pin(at_two), .remote_set_valid(set_valid),
        .remote_set_two(set_two), .remote_reset(remote_reset), .leds(leds),
        .relay_pulse_one(pulse_one), .relay_pulse_two(pulse_two), .selected_two(sel_two),
        .fault_closed(fault_closed), .reply_valid(reply_valid), .reply_data(reply_data),
        .history(history), .serial_rs422(serial_rs422), .baud_divisor(baud));
    rsc_partner #(.SETTLE(3)) i_far (.core_clk(core_clk), .relay_pulse_one(pulse_one),
        .relay_pulse_two(pulse_two), .channel_one_bad(one_bad), .channel_two_bad(two_bad),
        .alarm_on_closure(closure), .channel_one_alarm_pin(a1_pin),
        .channel_two_alarm_pin(a2_pin), .relay_at_two_pin(at_two));
    // free-running core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // hang guard, far above the thousand or so cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    task end_sim();
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    task idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask : idle
    // bounded wait for a position, then make sure it holds
    task sel_is(input logic exp);
        int n;
        n = 0;
        while (sel_two !== exp && n < 60) begin
            idle(1);
            n++;
        end
        idle(20);
        `CHK("selected_two", exp, sel_two)
    endtask : sel_is
    task step(input logic a, input logic b, input logic exp);
        idle(1);
        one_bad = a;
        two_bad = b;
        sel_is(exp);
    endtask : step
    // one-cycle remote request and its answer
    task remote_set(input logic two, input logic [7:0] exp);
        idle(1);
        set_valid = 1'b1;
        set_two = two;
        idle(1);
        set_valid = 1'b0;
        // the answer strobe stands for one cycle only: look at it now
        `CHK("reply_valid", 1'b1, reply_valid)
        `CHK("reply_data", exp, reply_data)
    endtask : remote_set
    task remote_pulse(input rsc_reset_req_t r);
        idle(1);
        remote_reset = r;
        idle(1);
        remote_reset = 2'h0;
    endtask : remote_pulse
    // panel buttons are held long enough to pass the debounce
    task press(input rsc_reset_req_t r);
        panel = r;
        idle(15);
        panel = 2'h0;
        idle(15);
    endtask : press
    // main sequence
    initial begin
        {rst, sup_a, sup_b, closure} = 4'hF;
        {one_bad, two_bad, fault_pin, rs422, set_valid, set_two} = 6'h00;
        {policy, selector, panel, remote_reset} = 8'h00;
        idle(6);
        rst = 1'b0;
        idle(20);
        `CHK("leds", 6'h03, leds)
        sup_b = 1'b0;
        idle(20);
        `CHK("leds", 6'h02, leds)
        sup_b = 1'b1;
        step(1'b0, 1'b1, 1'b0);
        step(1'b1, 1'b0, 1'b1);
        step(1'b1, 1'b1, 1'b0);
        `CHK("leds", 6'h33, leds)
        step(1'b1, 1'b0, 1'b1);
        step(1'b0, 1'b0, 1'b0);
        `CHK("history", 3'h7, history)
        remote_pulse(2'h1);
        sel_is(1'b0);
        `CHK("history", 3'h0, history)
        closure = 1'b0;
        step(1'b1, 1'b0, 1'b1);
        step(1'b0, 1'b0, 1'b0);
        policy = 2'h1;
        step(1'b1, 1'b0, 1'b1);
        step(1'b0, 1'b0, 1'b1);
        step(1'b1, 1'b1, 1'b1);
        step(1'b0, 1'b1, 1'b1);
        press(2'h2);
        sel_is(1'b0);
        step(1'b1, 1'b0, 1'b1);
        step(1'b0, 1'b0, 1'b1);
        remote_pulse(2'h2);
        sel_is(1'b0);
        policy = 2'h2;
        step(1'b1, 1'b0, 1'b1);
        step(1'b0, 1'b0, 1'b1);
        step(1'b1, 1'b1, 1'b1);
        step(1'b0, 1'b1, 1'b0);
        policy = 2'h3;
        step(1'b1, 1'b0, 1'b0);
        step(1'b0, 1'b0, 1'b0);
        policy = 2'h0;
        step(1'b0, 1'b0, 1'b0);
        remote_set(1'b1, REPLY_DONE);
        sel_is(1'b1);
        `CHK("remote_mode", 1'b1, leds.remote_mode)
        step(1'b1, 1'b1, 1'b1);
        remote_pulse(2'h2);
        sel_is(1'b0);
        `CHK("remote_mode", 1'b0, leds.remote_mode)
        step(1'b0, 1'b0, 1'b0);
        selector = 2'h1;
        sel_is(1'b1);
        `CHK("manual_mode", 1'b1, leds.manual_mode)
        remote_set(1'b0, REPLY_REFUSED);
        sel_is(1'b1);
        `CHK("remote_mode", 1'b0, leds.remote_mode)
        selector = 2'h2;
        sel_is(1'b0);
        selector = 2'h0;
        fault_pin = 1'b1;
        idle(2);
        fault_pin = 1'b0;
        idle(20);
        `CHK("fault_closed", 1'b0, fault_closed)
        fault_pin = 1'b1;
        idle(20);
        `CHK("fault_closed", 1'b1, fault_closed)
        fault_pin = 1'b0;
        rs422 = 1'b1;
        idle(20);
        `CHK("fault_closed", 1'b0, fault_closed)
        `CHK("serial_rs422", 1'b1, serial_rs422)
        `CHK("baud_divisor", 16'h65B9, baud)
        policy = 2'h1;
        step(1'b1, 1'b0, 1'b1);
        step(1'b0, 1'b0, 1'b1);
        rst = 1'b1;
        idle(6);
        rst = 1'b0;
        sel_is(1'b1);
        `CHK("relay_at_two", 1'b1, at_two)
        end_sim();
    end
endmodule : tb_top
